//--- sagc_chan.sv
/*
  One AGC loop channel: tracks an input level toward a target by
  stepping gain in half-dB, paced by a millisecond tick.
  Assumes decoded settings and levels come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sagc_params.svh"
module sagc_chan (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic agc_en,
  input wire sagc_pkg::sagc_byte_t tgt_att,
  input wire sagc_pkg::sagc_ms_t atk_ms,
  input wire sagc_pkg::sagc_ms_t dcy_ms,
  input wire sagc_pkg::sagc_gain_t ceil_gain,
  input wire logic noise_on,
  input wire sagc_pkg::sagc_byte_t thr_att,
  input wire sagc_pkg::sagc_byte_t hyst_att,
  input wire logic clip_en,
  input wire sagc_pkg::sagc_byte_t level,
  input wire logic sample_tick,
  input wire logic ms_tick,
  input wire logic double_rate_audio,
  output sagc_pkg::sagc_gain_t gain_ff
);
  import sagc_pkg::*;

  sagc_state_t state_ff;
  sagc_state_t nxt_state;
  sagc_gain_t nxt_gain;
  sagc_ms_t timer_ff;
  sagc_ms_t nxt_timer;
  logic signed [9:0] out_att;
  logic too_loud;
  logic too_quiet;
  logic clip;
  logic gate_close;
  logic gate_open;
  logic [1:0] tstep;
  logic tsat;

  // Level after gain and the loop decisions taken on it; the gate decisions use the level before gain
  assign out_att = $signed({2'b00, level}) - 10'(gain_ff);
  assign too_loud = out_att < $signed({2'b00, tgt_att});
  assign too_quiet = out_att > $signed({2'b00, tgt_att});
  assign clip = out_att <= 10'sh000;
  assign gate_close = noise_on && (level > thr_att);
  assign gate_open = !noise_on || ({1'b0, level} + {1'b0, hyst_att} <= {1'b0, thr_att});
  assign tstep = double_rate_audio ? 2'h2 : 2'h1;
  assign tsat = timer_ff > 10'h3FD;

  // Loop state, gain step and step timer
  always_comb begin
    nxt_state = state_ff;
    nxt_gain = gain_ff;
    nxt_timer = timer_ff;
    if (ms_tick && !tsat) begin
      nxt_timer = timer_ff + 10'(tstep);
    end
    case (state_ff)
      SAGC_OFF: begin
        nxt_gain = 8'sh00;
        nxt_timer = 10'h000;
        if (agc_en) begin
          nxt_state = SAGC_TRACK;
        end
      end
      SAGC_TRACK: begin
        if (!agc_en) begin
          nxt_state = SAGC_OFF;
        end else if (sample_tick) begin
          if (gate_close) begin
            nxt_state = SAGC_GATED;
          end else if (clip && clip_en && gain_ff > `SAGC_GAIN_MIN) begin
            nxt_gain = gain_ff - 8'sh01;
            nxt_timer = 10'h000;
          end else if (too_loud && timer_ff >= atk_ms) begin
            if (gain_ff > `SAGC_GAIN_MIN) begin
              nxt_gain = gain_ff - 8'sh01;
            end
            nxt_timer = 10'h000;
          end else if (too_quiet && timer_ff >= dcy_ms) begin
            nxt_gain = gain_ff + 8'sh01;
            nxt_timer = 10'h000;
          end else if (!too_loud && !too_quiet) begin
            nxt_timer = 10'h000;
          end
        end
      end
      SAGC_GATED: begin
        if (!agc_en) begin
          nxt_state = SAGC_OFF;
        end else if (!noise_on || (sample_tick && gate_open)) begin
          nxt_state = SAGC_TRACK;
          nxt_timer = 10'h000;
        end
      end
      default: begin
        nxt_state = SAGC_OFF;
      end
    endcase
    if (nxt_gain > ceil_gain) begin
      nxt_gain = ceil_gain;
    end
  end

  // State registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= SAGC_OFF;
      gain_ff <= 8'sh00;
      timer_ff <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      gain_ff <= nxt_gain;
      timer_ff <= nxt_timer;
    end
  end

  ceiling_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> gain_ff <= $past(ceil_gain)) else $error("gain above ceiling");

  off_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    !agc_en [*2] |=> gain_ff == 8'sh00) else $error("gain not cleared when off");

  noise_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !noise_on |=> state_ff != SAGC_GATED) else $error("gated with detection off");

  clip_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == SAGC_TRACK && agc_en && sample_tick && !gate_close && clip && clip_en
    && gain_ff > `SAGC_GAIN_MIN && gain_ff <= ceil_gain |=> gain_ff == $past(gain_ff) - 8'sh01)
    else $error("clip step missed");

  attack_pace_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_ff) == SAGC_TRACK && !$past(clip_en) && gain_ff < $past(gain_ff)
    && $past(gain_ff) <= $past(ceil_gain) |-> $past(timer_ff) >= $past(atk_ms))
    else $error("attack step too early");

  decay_pace_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(state_ff) == SAGC_TRACK && gain_ff > $past(gain_ff)
    |-> $past(timer_ff) >= $past(dcy_ms) && $past(too_quiet))
    else $error("decay step too early");

  gate_hyst_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == SAGC_GATED && noise_on && agc_en && sample_tick
    && ({1'b0, level} + {1'b0, hyst_att} > {1'b0, thr_att}) |=> state_ff == SAGC_GATED)
    else $error("gate opened inside hysteresis");

  dra_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_ff == SAGC_GATED && agc_en && noise_on && !sample_tick && ms_tick
    && double_rate_audio && !tsat |=> timer_ff == $past(timer_ff) + 10'h002)
    else $error("timer rate wrong with double rate");
endmodule // sagc_chan
`default_nettype wire

//--- sagc_params.svh
/*
  Constants of the stereo AGC control block: register offsets, field
  positions, reset values, level tables and timing counts.
  Assumes it is included by bare name after the package.
*/
`ifndef SAGC_PARAMS_SVH
`define SAGC_PARAMS_SVH

// Register offsets
`define SAGC_OFS_L_CTRL 8'h1A
`define SAGC_OFS_L_CEIL 8'h1B
`define SAGC_OFS_L_NOISE 8'h1C
`define SAGC_OFS_R_CTRL 8'h1D
`define SAGC_OFS_R_CEIL 8'h1E
`define SAGC_OFS_R_NOISE 8'h1F
`define SAGC_OFS_L_GAIN 8'h20
`define SAGC_OFS_R_GAIN 8'h21

// Reset values
`define SAGC_RST_CTRL 8'h00
`define SAGC_RST_CEIL 8'hFE
`define SAGC_RST_NOISE 8'h00

// Field positions
`define SAGC_EN_BIT 7
`define SAGC_TGT_HI 6
`define SAGC_TGT_LO 4
`define SAGC_ATK_HI 3
`define SAGC_ATK_LO 2
`define SAGC_DCY_HI 1
`define SAGC_DCY_LO 0
`define SAGC_CEIL_HI 7
`define SAGC_CEIL_LO 1
`define SAGC_HYST_HI 7
`define SAGC_HYST_LO 6
`define SAGC_THR_HI 5
`define SAGC_THR_LO 1
`define SAGC_CLIP_BIT 0

// Gain in half-dB steps; codes at or above the clamp code read as 59.5 dB
`define SAGC_CEIL_CLAMP 7'h77
`define SAGC_GAIN_MIN (-8'sh18)

// Target level, as attenuation below full scale in half-dB
`define SAGC_TGT_TABLE '{8'h0B, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h22, 8'h28, 8'h30}
// Noise threshold: code 1 is -30 dB, then 2 dB (4 half-dB) per code
`define SAGC_THR_BASE 8'h38
// Hysteresis in half-dB for codes 00, 01, 10, 11 (off)
`define SAGC_HYST_TABLE '{8'h02, 8'h04, 8'h08, 8'h00}

// Attack and decay times in ms
`define SAGC_ATK_TABLE '{10'h008, 10'h00B, 10'h010, 10'h014}
`define SAGC_DCY_TABLE '{10'h064, 10'h0C8, 10'h190, 10'h1F4}

// Timing base
`define SAGC_CLK_KHZ 200000
`define SAGC_TICK_MS 1
`define SAGC_TICK_CYC (`SAGC_TICK_MS * `SAGC_CLK_KHZ)

`endif

//--- sagc_pkg.sv
/*
  Types shared by the stereo AGC control block.
  Assumes nothing of its surroundings.
*/
package sagc_pkg;
  typedef logic signed [7:0] sagc_gain_t;
  typedef logic [7:0] sagc_byte_t;
  typedef logic [9:0] sagc_ms_t;
  typedef enum logic [1:0] {SAGC_OFF, SAGC_TRACK, SAGC_GATED} sagc_state_t;
endpackage

//--- sagc_regs.sv
/*
  Control register set of the stereo record AGC, with field decoding,
  a millisecond tick divider and one AGC loop per channel.
  Assumes the register port, sample tick, levels and double rate flag
  come from logic on clk; no synchronisers are placed on them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sagc_params.svh"
module sagc_regs #(
  parameter int TICK_CYC = `SAGC_TICK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire sagc_pkg::sagc_byte_t reg_addr,
  input wire sagc_pkg::sagc_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output sagc_pkg::sagc_byte_t reg_rdata_ff,
  input wire logic sample_tick,
  input wire logic double_rate_audio,
  input wire sagc_pkg::sagc_byte_t left_level,
  input wire sagc_pkg::sagc_byte_t right_level,
  output sagc_pkg::sagc_gain_t left_gain_ff,
  output sagc_pkg::sagc_gain_t right_gain_ff
);
  import sagc_pkg::*;

  localparam sagc_byte_t TGT_LUT [8] = `SAGC_TGT_TABLE;
  localparam sagc_byte_t HYST_LUT [4] = `SAGC_HYST_TABLE;
  localparam sagc_ms_t ATK_LUT [4] = `SAGC_ATK_TABLE;
  localparam sagc_ms_t DCY_LUT [4] = `SAGC_DCY_TABLE;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////
  // Register storage

  sagc_byte_t l_ctrl_ff;
  sagc_byte_t l_ceil_ff;
  sagc_byte_t l_noise_ff;
  sagc_byte_t r_ctrl_ff;
  sagc_byte_t r_ceil_ff;
  sagc_byte_t r_noise_ff;

  // Write decode
  wire wr_l_ctrl = reg_wr && reg_addr == `SAGC_OFS_L_CTRL;
  wire wr_l_ceil = reg_wr && reg_addr == `SAGC_OFS_L_CEIL;
  wire wr_l_noise = reg_wr && reg_addr == `SAGC_OFS_L_NOISE;
  wire wr_r_ctrl = reg_wr && reg_addr == `SAGC_OFS_R_CTRL;
  wire wr_r_ceil = reg_wr && reg_addr == `SAGC_OFS_R_CEIL;
  wire wr_r_noise = reg_wr && reg_addr == `SAGC_OFS_R_NOISE;

  // Control registers; the ceilings reset to the top code
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      l_ctrl_ff <= `SAGC_RST_CTRL;
      l_ceil_ff <= `SAGC_RST_CEIL;
      l_noise_ff <= `SAGC_RST_NOISE;
      r_ctrl_ff <= `SAGC_RST_CTRL;
      r_ceil_ff <= `SAGC_RST_CEIL;
      r_noise_ff <= `SAGC_RST_NOISE;
    end else begin
      if (wr_l_ctrl) begin
        l_ctrl_ff <= reg_wdata;
      end
      if (wr_l_ceil) begin
        l_ceil_ff <= reg_wdata;
      end
      if (wr_l_noise) begin
        l_noise_ff <= reg_wdata;
      end
      if (wr_r_ctrl) begin
        r_ctrl_ff <= reg_wdata;
      end
      if (wr_r_ceil) begin
        r_ceil_ff <= reg_wdata;
      end
      if (wr_r_noise) begin
        r_noise_ff <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Field decoding, left channel

  wire [6:0] l_ceil_code = l_ceil_ff[`SAGC_CEIL_HI:`SAGC_CEIL_LO];
  wire [4:0] l_thr_code = l_noise_ff[`SAGC_THR_HI:`SAGC_THR_LO];
  wire l_en = l_ctrl_ff[`SAGC_EN_BIT];
  wire sagc_byte_t l_tgt = TGT_LUT[l_ctrl_ff[`SAGC_TGT_HI:`SAGC_TGT_LO]];
  wire sagc_ms_t l_atk = ATK_LUT[l_ctrl_ff[`SAGC_ATK_HI:`SAGC_ATK_LO]];
  wire sagc_ms_t l_dcy = DCY_LUT[l_ctrl_ff[`SAGC_DCY_HI:`SAGC_DCY_LO]];
  // Ceiling in half-dB, clamped at 59.5 dB
  wire sagc_gain_t l_ceil = (l_ceil_code >= `SAGC_CEIL_CLAMP) ?
    sagc_gain_t'({1'b0, `SAGC_CEIL_CLAMP}) : sagc_gain_t'({1'b0, l_ceil_code});
  wire l_noise_on = l_thr_code != 5'h00;
  wire sagc_byte_t l_thr = `SAGC_THR_BASE + {1'b0, l_thr_code, 2'b00};
  wire sagc_byte_t l_hyst = HYST_LUT[l_noise_ff[`SAGC_HYST_HI:`SAGC_HYST_LO]];
  wire l_clip_en = l_noise_ff[`SAGC_CLIP_BIT];

  ////////////////////////////////////////////////////////////////
  // Field decoding, right channel

  wire [6:0] r_ceil_code = r_ceil_ff[`SAGC_CEIL_HI:`SAGC_CEIL_LO];
  wire [4:0] r_thr_code = r_noise_ff[`SAGC_THR_HI:`SAGC_THR_LO];
  wire r_en = r_ctrl_ff[`SAGC_EN_BIT];
  wire sagc_byte_t r_tgt = TGT_LUT[r_ctrl_ff[`SAGC_TGT_HI:`SAGC_TGT_LO]];
  wire sagc_ms_t r_atk = ATK_LUT[r_ctrl_ff[`SAGC_ATK_HI:`SAGC_ATK_LO]];
  wire sagc_ms_t r_dcy = DCY_LUT[r_ctrl_ff[`SAGC_DCY_HI:`SAGC_DCY_LO]];
  // Same half-dB coding and clamp as the left side
  wire sagc_gain_t r_ceil = (r_ceil_code >= `SAGC_CEIL_CLAMP) ?
    sagc_gain_t'({1'b0, `SAGC_CEIL_CLAMP}) : sagc_gain_t'({1'b0, r_ceil_code});
  wire r_noise_on = r_thr_code != 5'h00;
  wire sagc_byte_t r_thr = `SAGC_THR_BASE + {1'b0, r_thr_code, 2'b00};
  wire sagc_byte_t r_hyst = HYST_LUT[r_noise_ff[`SAGC_HYST_HI:`SAGC_HYST_LO]];
  wire r_clip_en = r_noise_ff[`SAGC_CLIP_BIT];

  ////////////////////////////////////////////////////////////////
  // Millisecond tick divider pacing attack and decay

  logic [31:0] div_ff;
  logic ms_tick_ff;
  wire div_wrap = div_ff >= TICK_LAST;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff <= 32'h0000_0000;
      ms_tick_ff <= 1'b0;
    end else begin
      div_ff <= div_wrap ? 32'h0000_0000 : div_ff + 32'h0000_0001;
      ms_tick_ff <= div_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////
  // AGC loops

  sagc_chan u_left (
    .clk(clk),
    .sys_rst(sys_rst),
    .agc_en(l_en),
    .tgt_att(l_tgt),
    .atk_ms(l_atk),
    .dcy_ms(l_dcy),
    .ceil_gain(l_ceil),
    .noise_on(l_noise_on),
    .thr_att(l_thr),
    .hyst_att(l_hyst),
    .clip_en(l_clip_en),
    .level(left_level),
    .sample_tick(sample_tick),
    .ms_tick(ms_tick_ff),
    .double_rate_audio(double_rate_audio),
    .gain_ff(left_gain_ff)
  );

  sagc_chan u_right (
    .clk(clk),
    .sys_rst(sys_rst),
    .agc_en(r_en),
    .tgt_att(r_tgt),
    .atk_ms(r_atk),
    .dcy_ms(r_dcy),
    .ceil_gain(r_ceil),
    .noise_on(r_noise_on),
    .thr_att(r_thr),
    .hyst_att(r_hyst),
    .clip_en(r_clip_en),
    .level(right_level),
    .sample_tick(sample_tick),
    .ms_tick(ms_tick_ff),
    .double_rate_audio(double_rate_audio),
    .gain_ff(right_gain_ff)
  );

  ////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, zero when unmapped

  sagc_byte_t rd_mux;
  assign rd_mux =
    (reg_addr == `SAGC_OFS_L_CTRL) ? l_ctrl_ff :
    (reg_addr == `SAGC_OFS_L_CEIL) ? l_ceil_ff :
    (reg_addr == `SAGC_OFS_L_NOISE) ? l_noise_ff :
    (reg_addr == `SAGC_OFS_R_CTRL) ? r_ctrl_ff :
    (reg_addr == `SAGC_OFS_R_CEIL) ? r_ceil_ff :
    (reg_addr == `SAGC_OFS_R_NOISE) ? r_noise_ff :
    (reg_addr == `SAGC_OFS_L_GAIN) ? sagc_byte_t'(left_gain_ff) :
    (reg_addr == `SAGC_OFS_R_GAIN) ? sagc_byte_t'(right_gain_ff) :
    8'h00;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks

  clamp_left_a: assert property (@(posedge clk) disable iff (sys_rst)
    l_ceil_code >= `SAGC_CEIL_CLAMP |=> left_gain_ff <= 8'sh77)
    else $error("left ceiling clamp wrong");

  ceil_right_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_r_ceil ##1 !wr_r_ceil |=> right_gain_ff <= $signed({1'b0, $past(reg_wdata, 2) >> 1}))
    else $error("right gain above written ceiling");

  thr_right_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_r_noise && reg_wdata[5:1] == 5'h1F |=> r_thr == 8'hB4)
    else $error("right threshold code 31 not -90 dB");

  thr_left_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_l_noise && reg_wdata[5:1] == 5'h01 |=> l_thr == 8'h3C)
    else $error("left threshold code 1 not -30 dB");

  read_back_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_r_ctrl ##1 reg_rd && reg_addr == `SAGC_OFS_R_CTRL && !reg_wr
    |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("right control readback wrong");

  tick_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    ms_tick_ff && TICK_CYC > 1 |=> !ms_tick_ff)
    else $error("ms tick not a single pulse");
endmodule // sagc_regs
`default_nettype wire

//--- sagc_regs_tb.sv
/*
  Self-checking testbench of the stereo AGC control registers and loops.
  Assumes the register port and loop timing of the design,
  with a 10-cycle millisecond tick to keep the run short.
*/
`timescale 1ns/1ps
`default_nettype none
module sagc_regs_tb;
  import sagc_pkg::*;
  localparam int TICK = 10;
  localparam int TGT[8] = '{11, 16, 20, 24, 28, 34, 40, 48};
  localparam int ATK[4] = '{8, 11, 16, 20};
  localparam int DCY[4] = '{100, 200, 400, 500};
  localparam logic [7:0] THR[3] = '{8'h00, 8'h01, 8'h1F};
  localparam logic [7:0] GEXP[3] = '{8'h01, 8'h00, 8'h01};
  localparam logic [7:0] PAT[6] = '{8'h6B, 8'hA4, 8'hD7, 8'h5E, 8'h0C, 8'hB3};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sample_tick = 1'b0;
  logic double_rate_audio = 1'b0;
  sagc_byte_t reg_addr = 8'h00;
  sagc_byte_t reg_wdata = 8'h00;
  sagc_byte_t left_level = 8'h00;
  sagc_byte_t right_level = 8'h00;
  sagc_byte_t reg_rdata_ff;
  sagc_gain_t left_gain_ff;
  sagc_gain_t right_gain_ff;
  int err_count = 0;
  int compares = 0;
  int n;
  int e;

  sagc_regs #(.TICK_CYC(TICK)) sagc_regs_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff),
    .sample_tick(sample_tick),
    .double_rate_audio(double_rate_audio),
    .left_level(left_level),
    .right_level(right_level),
    .left_gain_ff(left_gain_ff),
    .right_gain_ff(right_gain_ff)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and a sample pulse every other cycle
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    sample_tick <= ~sample_tick;
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and register port tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle read strobe; the data are taken at the edge that closes the cycle after it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(what, reg_rdata_ff, exp);
  endtask

  task automatic idle(input int cyc);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (cyc) @(posedge clk);
  endtask

  // Cycles until the channel gain first leaves zero, bounded
  task automatic first_step(input int ch, output int cyc);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    cyc = 0;
    while (((ch == 0) ? left_gain_ff : right_gain_ff) === 8'h00 && cyc < 6000) begin
      @(posedge clk);
      cyc++;
    end
  endtask

  task automatic in_range(input string what, input int cyc, input int lo, input int hi);
    chk(what, {7'h00, (cyc >= lo && cyc <= hi)}, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main test sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Reset values and the read-only right gain
    rd(8'h1A, 8'h00, "left ctrl reset");
    rd(8'h1B, 8'hFE, "left ceiling reset");
    rd(8'h1C, 8'h00, "left noise reset");
    rd(8'h1D, 8'h00, "right ctrl reset");
    rd(8'h1E, 8'hFE, "right ceiling reset");
    rd(8'h1F, 8'h00, "right noise reset");
    rd(8'h21, 8'h00, "right gain reset");
    // Back-to-back writes then reads of every field
    for (int i = 0; i < 6; i++) wr(8'h1A + 8'(i), PAT[i]);
    for (int i = 0; i < 6; i++) rd(8'h1A + 8'(i), PAT[i], "readback");
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00, "read-only gain");
    rd(8'hFF, 8'h00, "unmapped read");
    idle(1);
    chk("read data after one cycle", reg_rdata_ff, 8'h00);
    wr(8'h1C, 8'h00);
    wr(8'h1F, 8'h00);
    wr(8'h1B, 8'hFE);
    wr(8'h1E, 8'hFE);
    wr(8'h1D, 8'h4E);
    rd(8'h1D, 8'h4E, "right ctrl write then read");
    wr(8'h1D, 8'h00);
    idle(3);
    // Target levels: one attack step to reach the target, then hold
    for (int i = 0; i < 8; i++) begin
      right_level <= 8'(TGT[i] - 1);
      wr(8'h1D, 8'h80 | 8'(i << 4));
      idle(260);
      chk("right gain at target", right_gain_ff, 8'hFF);
      wr(8'h1D, 8'h00);
      idle(3);
      chk("right gain when off", right_gain_ff, 8'h00);
    end
    // Attack times at normal and double rate
    right_level <= 8'h00;
    for (int d = 0; d < 2; d++) begin
      double_rate_audio <= d[0];
      for (int a = 0; a < 4; a++) begin
        e = ((ATK[a] + d) / (d + 1)) * TICK;
        wr(8'h1D, 8'h80 | 8'(a << 2));
        first_step(1, n);
        in_range("attack time", n, e - 12, e + 16);
        chk("attack direction", right_gain_ff, 8'hFF);
        wr(8'h1D, 8'h00);
        idle(3);
      end
    end
    double_rate_audio <= 1'b0;
    // Decay times
    right_level <= 8'd100;
    for (int d = 0; d < 4; d++) begin
      e = DCY[d] * TICK;
      wr(8'h1D, 8'h80 | 8'(d));
      first_step(1, n);
      in_range("decay time", n, e - 12, e + 16);
      chk("decay direction", right_gain_ff, 8'h01);
      wr(8'h1D, 8'h00);
      idle(3);
    end
    // Gain held at a low ceiling, then clamped when it is lowered
    wr(8'h1E, 8'h02);
    wr(8'h1D, 8'h80);
    idle(3500);
    chk("right gain at ceiling", right_gain_ff, 8'h01);
    rd(8'h21, 8'h01, "right gain readback");
    wr(8'h1E, 8'h00);
    idle(3);
    chk("right gain after lowering", right_gain_ff, 8'h00);
    wr(8'h1D, 8'h00);
    wr(8'h1E, 8'hFE);
    idle(3);
    // Clip stepping on either channel bypasses the attack timer
    left_level <= 8'h00;
    right_level <= 8'h00;
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 1; c >= 0; c--) begin
        wr(8'h1C + 8'(3 * ch), 8'(c));
        wr(8'h1A + 8'(3 * ch), 8'h80);
        first_step(ch, n);
        if (c == 1) in_range("clip step time", n, 0, 10);
        else in_range("no clip step time", n, 68, 96);
        wr(8'h1A + 8'(3 * ch), 8'h00);
        idle(3);
      end
    end
    // Noise gate per channel: off, threshold above and below the level
    left_level <= 8'd100;
    right_level <= 8'd100;
    for (int ch = 0; ch < 2; ch++) begin
      for (int t = 0; t < 3; t++) begin
        // Double rate only in the gated pass, where the held timer steps by two
        double_rate_audio <= (t == 1);
        wr(8'h1C + 8'(3 * ch), 8'hC0 | (THR[t] << 1));
        wr(8'h1A + 8'(3 * ch), 8'h80);
        idle(1150);
        chk("gated gain", (ch == 0) ? left_gain_ff : right_gain_ff, GEXP[t]);
        wr(8'h1A + 8'(3 * ch), 8'h00);
        idle(3);
      end
    end
    // A 4 dB hysteresis keeps the right gate shut until the level drops past it
    double_rate_audio <= 1'b0;
    right_level <= 8'd100;
    wr(8'h1F, 8'h82);
    wr(8'h1D, 8'h80);
    idle(20);
    right_level <= 8'd58;
    idle(1150);
    chk("gate held by hysteresis", right_gain_ff, 8'h00);
    right_level <= 8'd50;
    idle(1150);
    chk("gate reopened below hysteresis", right_gain_ff, 8'h01);
    report_and_stop();
  end
endmodule // sagc_regs_tb
`default_nettype wire
